// ### rtl/qdsm_device.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Single accesses use sampled external address
// - One select low, write-select low: read
// - One select low, write-select high: write
// - Host drives at most one select low; the host drives all four low in sequential mode
// - Sequential read needs all selects, flags
// - Counter starts zero, steps each edge
// - Sequential without flags: disable, counter cleared
// - Host holds selects, write-select low
// - Host keeps sequential mode low singly
// - Byte width mode floats upper byte
// - Overflow output always driven
// - Error outputs always driven, read die
// - Sequential: only current die error valid
// - Host waits startup time before access
// - Writes blocked while supply low
module qdsm_device #(
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link
  qdsm_if.device lnk
);
  localparam int CW = AW + 3;
  localparam int DW_C = qdsm_pkg::DATA_W;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic ovf_q;
  logic seq_run;
  logic seq_off;
  logic one_low;
  logic [1:0] die_sel;
  logic [1:0] die_act;
  logic [AW-1:0] mem_addr;
  logic single_rd;
  logic single_wr;
  logic rd_q;
  logic seq_rd_q;
  logic x8_q;
  logic [1:0] rdie_q;
  logic lo_half_q;
  logic [3:0] we_v;
  logic [DW_C-1:0] rdata [4];
  logic [3:0] err_v;
  logic [15:0] dq_q;
  logic [3:0] err_q;
  logic err_vld_q;

  assign one_low = (lnk.sel_n == 4'h_E) || (lnk.sel_n == 4'h_D)
                 || (lnk.sel_n == 4'h_B) || (lnk.sel_n == 4'h_7);
  assign die_sel = ~lnk.sel_n[0] ? 2'd0 : ~lnk.sel_n[1] ? 2'd1 :
                   ~lnk.sel_n[2] ? 2'd2 : 2'd3;
  assign single_rd = ~lnk.sequential_mode & one_low & ~lnk.write_sel;
  assign single_wr = ~lnk.sequential_mode & one_low & lnk.write_sel
                   & lnk.write_ok;
  assign seq_run = lnk.sequential_mode & (lnk.sel_n == qdsm_pkg::SEL_ALL)
                 & lnk.init & ~lnk.done & lnk.ovf_in & ~ovf_q;
  assign seq_off = lnk.sequential_mode & ~(lnk.init & ~lnk.done & lnk.ovf_in);
  // In x8 mode each word holds two bytes, so the die boundary moves up one bit
  assign die_act = seq_run ? (lnk.byte_width_select ? cnt_q[AW+2:AW+1] : cnt_q[AW+1:AW])
                           : die_sel;
  assign mem_addr = seq_run ? (lnk.byte_width_select ? cnt_q[AW:1] : cnt_q[AW-1:0])
                            : lnk.addr[AW-1:0];

  always_comb begin
    cnt_d = cnt_q;
    if (seq_off) begin
      cnt_d = '0;
    end else if (seq_run) begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (seq_off || !lnk.sequential_mode) begin
        ovf_q <= 1'b0;
      end else if (seq_run) begin
        // Last location of die 3 read: counter carries into top bit in x16 mode, wraps to zero in x8 mode
        ovf_q <= lnk.byte_width_select ? (cnt_q[AW+2:0] == '1)
                                       : (cnt_q[AW+1:0] == '1);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_die
      assign we_v[g] = single_wr & (die_sel == 2'(g));
      qdsm_die_mem #(.AW(AW), .DW(DW_C)) u_mem (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .we_i(we_v[g]),
        .addr_i(mem_addr),
        .wdata_i(lnk.dq_h2d),
        .rdata_o(rdata[g]),
        .err_o(err_v[g])
      );
    end
  endgenerate

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= 1'b0;
      seq_rd_q <= 1'b0;
      x8_q <= 1'b0;
      rdie_q <= 2'd0;
      lo_half_q <= 1'b0;
      err_vld_q <= 1'b0;
    end else begin
      rd_q <= single_rd | seq_run;
      seq_rd_q <= seq_run;
      x8_q <= lnk.byte_width_select;
      lo_half_q <= seq_run & lnk.byte_width_select & ~cnt_q[0];
      // Data and error stay with the last die read until the next access
      if (single_rd || seq_run) begin
        rdie_q <= die_act;
        err_vld_q <= 1'b1;
      end else if (~lnk.sequential_mode & one_low & lnk.write_sel) begin
        err_vld_q <= 1'b0;
      end
    end
  end

  always_comb begin
    dq_q = rdata[rdie_q];
    if (x8_q) begin
      dq_q = {8'h_00, (seq_rd_q && !lo_half_q) ? rdata[rdie_q][15:8] : rdata[rdie_q][7:0]};
    end
    err_q = 4'h_0;
    err_q[rdie_q] = err_vld_q & err_v[rdie_q];
  end

  assign lnk.dq_d2h = dq_q;
  assign lnk.err = err_q;
  assign lnk.ovf_out = ovf_q;
  // Output enable low while driving; upper byte floats in x8 mode
  assign lnk.dq_oe_n[7:0] = ~(rd_q & (seq_rd_q | lnk.out_en));
  assign lnk.dq_oe_n[15:8] = ~(rd_q & (seq_rd_q | lnk.out_en) & ~x8_q
                             & ~lnk.byte_width_select);
endmodule

// ### rtl/qdsm_die_mem.sv
`timescale 1ns/10ps
module qdsm_die_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  // Clock
  input wire logic clock_i,
  input wire logic rst_i,
  // Access
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o,
  output logic err_o
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_q;
  // Parity-free model; error stays low unless location never written
  logic [2**AW-1:0] vld_q;
  logic err_q;

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_q <= mem_q[addr_i];
  end

  // Written flags need a reset, or an unwritten location reads as unknown
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vld_q <= '0;
      err_q <= 1'b0;
    end else begin
      if (we_i) begin
        vld_q[addr_i] <= 1'b1;
      end
      err_q <= ~vld_q[addr_i];
    end
  end

  assign rdata_o = rdata_q;
  assign err_o = err_q;
endmodule

// ### rtl/qdsm_host.sv
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module qdsm_host #(
  parameter int STARTUP = qdsm_pkg::STARTUP_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o,
  // Link
  qdsm_if.host lnk
);
  typedef enum logic [1:0] {
    QDSM_IDLE = 2'b00,
    QDSM_ACC = 2'b01,
    QDSM_WAIT = 2'b10,
    QDSM_SEQ = 2'b11
  } qdsm_st_t;
  qdsm_st_t st_q;
  logic [31:0] ctrl_q;
  logic [20:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [2:0] irq_q;
  logic [2:0] mask_q;
  logic [21:0] boot_q;
  logic [3:0] tmr_q;
  logic ap_wr_q;
  logic ap_rd_q;
  logic [7:0] ap_off_q;
  logic ready_run;
  logic ev_done;
  logic ev_ovf;
  logic ev_err;
  logic rd_irq;
  logic go_w;
  logic [3:0] err_sel;
  logic seq_first_q;

  wire ap_valid = hsel_i & hready_i & htrans_i[1];
  assign ready_run = (boot_q == 22'(STARTUP));
  assign go_w = ap_wr_q & (ap_off_q == qdsm_pkg::OFF_CTRL) & hwdata_i[qdsm_pkg::CTRL_GO];
  assign rd_irq = ap_rd_q & (ap_off_q == qdsm_pkg::OFF_IRQ);
  assign err_sel = lnk.err & ~qdsm_pkg::qdsm_onehot_low(ctrl_q[9:8]);
  assign ev_done = (st_q == QDSM_WAIT) && (tmr_q == 4'h_0);
  assign ev_ovf = (st_q == QDSM_SEQ) && lnk.ovf_out;
  assign ev_err = ev_done && !ctrl_q[qdsm_pkg::CTRL_WR] && (err_sel != 4'h_0);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_off_q <= 8'h_00;
    end else begin
      ap_wr_q <= ap_valid & hwrite_i;
      ap_rd_q <= ap_valid & ~hwrite_i;
      ap_off_q <= haddr_i[7:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= 32'h_0000_0000;
      addr_q <= 21'h_00_0000;
      wdata_q <= 16'h_0000;
      mask_q <= qdsm_pkg::MASK_RST;
    end else if (ap_wr_q) begin
      case (ap_off_q)
        qdsm_pkg::OFF_CTRL: ctrl_q <= hwdata_i;
        qdsm_pkg::OFF_ADDR: addr_q <= hwdata_i[20:0];
        qdsm_pkg::OFF_WDATA: wdata_q <= hwdata_i[15:0];
        qdsm_pkg::OFF_MASK: mask_q <= hwdata_i[2:0];
        default: ;
      endcase
    end
  end

  // Set wins over the read-clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 3'h_0;
    end else begin
      irq_q <= (rd_irq ? 3'h_0 : irq_q) | {ev_err, ev_ovf, ev_done};
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      boot_q <= 22'h_00_0000;
    end else if (!ready_run) begin
      boot_q <= boot_q + 22'h_00_0001;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= QDSM_IDLE;
      tmr_q <= 4'h_0;
      rdata_q <= 16'h_0000;
      seq_first_q <= 1'b0;
    end else begin
      seq_first_q <= 1'b0;
      case (st_q)
        QDSM_IDLE: begin
          if (go_w && ready_run) begin
            st_q <= hwdata_i[qdsm_pkg::CTRL_SEQ] ? QDSM_SEQ : QDSM_ACC;
            seq_first_q <= hwdata_i[qdsm_pkg::CTRL_SEQ];
          end
        end
        QDSM_ACC: begin
          st_q <= QDSM_WAIT;
          tmr_q <= ctrl_q[qdsm_pkg::CTRL_WR] ? 4'(qdsm_pkg::WRITE_CYC)
                                             : 4'(qdsm_pkg::READ_CYC);
        end
        QDSM_WAIT: begin
          if (tmr_q == 4'h_0) begin
            st_q <= QDSM_IDLE;
            rdata_q <= lnk.dq_d2h;
          end else begin
            tmr_q <= tmr_q - 4'h_1;
          end
        end
        QDSM_SEQ: begin
          rdata_q <= lnk.dq_d2h;
          if (lnk.ovf_out || (ap_wr_q && ap_off_q == qdsm_pkg::OFF_CTRL
              && hwdata_i[qdsm_pkg::CTRL_STOP])) begin
            st_q <= QDSM_IDLE;
          end
        end
        default: st_q <= QDSM_IDLE;
      endcase
    end
  end

  wire busy = (st_q != QDSM_IDLE);
  wire acc = (st_q == QDSM_ACC);
  wire seq = (st_q == QDSM_SEQ);
  assign lnk.sel_n = seq ? qdsm_pkg::SEL_ALL :
                     acc ? qdsm_pkg::qdsm_onehot_low(ctrl_q[9:8]) :
                     qdsm_pkg::SEL_NONE;
  assign lnk.write_sel = acc & ctrl_q[qdsm_pkg::CTRL_WR] & ~seq;
  assign lnk.sequential_mode = seq;
  // Init low on the first cycle, so every run restarts the counter at zero
  assign lnk.init = seq & ~seq_first_q;
  assign lnk.done = 1'b0;
  assign lnk.ovf_in = 1'b1;
  assign lnk.addr = addr_q;
  assign lnk.out_en = ctrl_q[qdsm_pkg::CTRL_OE];
  assign lnk.byte_width_select = ctrl_q[qdsm_pkg::CTRL_X8];
  assign lnk.dq_h2d = wdata_q;

  always_comb begin
    case (ap_off_q)
      qdsm_pkg::OFF_CTRL: hrdata_o = ctrl_q;
      qdsm_pkg::OFF_ADDR: hrdata_o = {11'h_000, addr_q};
      qdsm_pkg::OFF_WDATA: hrdata_o = {16'h_0000, wdata_q};
      qdsm_pkg::OFF_RDATA: hrdata_o = {16'h_0000, rdata_q};
      qdsm_pkg::OFF_STAT: hrdata_o = {29'h_0, ready_run, lnk.ovf_out, busy};
      qdsm_pkg::OFF_IRQ: hrdata_o = {29'h_0, irq_q};
      qdsm_pkg::OFF_MASK: hrdata_o = {29'h_0, mask_q};
      default: hrdata_o = 32'h_0000_0000;
    endcase
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign irq_o = |(irq_q & mask_q);
endmodule

// ### rtl/qdsm_if.sv
`timescale 1ns/10ps
interface qdsm_if;
  logic [3:0] sel_n;
  logic write_sel;
  logic [qdsm_pkg::ADDR_W-1:0] addr;
  logic out_en;
  logic byte_width_select;
  logic sequential_mode;
  logic init;
  logic done;
  logic ovf_in;
  logic ovf_out;
  logic [3:0] err;
  logic [qdsm_pkg::DATA_W-1:0] dq_h2d;
  logic [qdsm_pkg::DATA_W-1:0] dq_d2h;
  logic [qdsm_pkg::DATA_W-1:0] dq_oe_n;
  logic write_ok;
  modport device (
    input sel_n, write_sel, addr, out_en, byte_width_select, sequential_mode,
    input init, done, ovf_in, dq_h2d, write_ok,
    output ovf_out, err, dq_d2h, dq_oe_n
  );
  modport host (
    output sel_n, write_sel, addr, out_en, byte_width_select, sequential_mode,
    output init, done, ovf_in, dq_h2d,
    input ovf_out, err, dq_d2h, dq_oe_n
  );
endinterface

// ### rtl/qdsm_pkg.sv
package qdsm_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int DIE_N = 4;
  localparam int SEQ_W = 23;
  // Device timing, in ns, and the derived cycle counts at 25 MHz
  localparam int CLK_NS = 40;
  localparam int STARTUP_NS = 2000000;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC_NS = 130;
  localparam int READ_CYC = (READ_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC_NS = 150;
  localparam int WRITE_CYC = (WRITE_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SEL_NONE = 4'h_F;
  localparam logic [3:0] SEL_ALL = 4'h_0;
  // Controller register offsets
  localparam logic [7:0] OFF_CTRL = 8'h_00;
  localparam logic [7:0] OFF_ADDR = 8'h_04;
  localparam logic [7:0] OFF_WDATA = 8'h_08;
  localparam logic [7:0] OFF_RDATA = 8'h_0C;
  localparam logic [7:0] OFF_STAT = 8'h_10;
  localparam logic [7:0] OFF_IRQ = 8'h_14;
  localparam logic [7:0] OFF_MASK = 8'h_18;
  // CTRL fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_SEQ = 2;
  localparam int CTRL_STOP = 3;
  localparam int CTRL_X8 = 4;
  localparam int CTRL_OE = 5;
  localparam int CTRL_DIE_LO = 8;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_ERR = 2;
  localparam logic [2:0] MASK_RST = 3'h_0;

  function automatic logic [3:0] qdsm_onehot_low(input logic [1:0] die);
    qdsm_onehot_low = ~(4'h_1 << die);
  endfunction
endpackage

// ### tb/qdsm_checker.sv
`timescale 1ns/10ps
module qdsm_checker #(
  parameter int AW = 6,
  parameter int STARTUP = 20
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link
  input wire logic [3:0] sel_n,
  input wire logic write_sel,
  input wire logic byte_width_select,
  input wire logic sequential_mode,
  input wire logic init,
  input wire logic done,
  input wire logic ovf_in,
  input wire logic ovf_out,
  input wire logic [qdsm_pkg::DATA_W-1:0] dq_oe_n
);
  localparam int LAST = qdsm_pkg::DIE_N << AW;
  localparam int LAST2 = LAST * 2;
  logic [31:0] up_q;
  logic [31:0] run_q;
  wire seq_go = sequential_mode && init && !done && ovf_in;
  wire seq_run = seq_go && (sel_n == qdsm_pkg::SEL_ALL);
  // Byte mode reads two bytes per word, so the run is twice as long
  wire [31:0] last_n = byte_width_select ? 32'(LAST2) : 32'(LAST);
  wire all_z = &dq_oe_n;
  wire one_sel = (sel_n != qdsm_pkg::SEL_NONE) && (sel_n != qdsm_pkg::SEL_ALL);
  // Saturates so a long run cannot wrap back under the startup figure
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      up_q <= '0;
      run_q <= '0;
    end else begin
      up_q <= (up_q < STARTUP) ? up_q + 32'h0000_0001 : up_q;
      run_q <= seq_run ? run_q + 32'h0000_0001 : '0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_one_select: assert property (!sequential_mode |-> $countones(~sel_n) <= 1)
    else $error("more than one die selected");
  a_seq_hold: assert property (seq_go |-> sel_n == qdsm_pkg::SEL_ALL && !write_sel)
    else $error("sequential read without all selects low");
  a_single_plain: assert property (one_sel |-> !sequential_mode)
    else $error("sequential mode during single access");
  a_x8_upper: assert property (byte_width_select |-> &dq_oe_n[15:8])
    else $error("upper byte driven in byte mode");
  a_idle_float: assert property ((sel_n == qdsm_pkg::SEL_NONE)[*2] |-> all_z)
    else $error("data driven with no die selected");
  a_seq_abort: assert property (sequential_mode && !seq_go |=> all_z)
    else $error("data driven in aborted sequential mode");
  a_write_float: assert property (write_sel && one_sel |=> all_z)
    else $error("data driven during write");
  a_ovf_early: assert property ($rose(ovf_out) |-> run_q == last_n)
    else $error("overflow before last location");
  a_ovf_late: assert property (run_q == last_n |-> ovf_out)
    else $error("no overflow after last location");
  a_startup: assert property (sel_n != qdsm_pkg::SEL_NONE |-> up_q >= STARTUP - 1)
    else $error("die selected before startup wait");
  c_seq: cover property (seq_run ##1 seq_run);
  c_ovf: cover property ($rose(ovf_out));
  c_write: cover property (write_sel && one_sel);
  c_x8: cover property (byte_width_select && !(&dq_oe_n[7:0]));
  c_prime: cover property (sequential_mode && !seq_go);
endmodule

// ### tb/tb_quad_die_sync_mram_port.sv
`timescale 1ns/10ps
module tb_quad_die_sync_mram_port;
  localparam int STARTUP = 20;
  localparam int AW = 6;
  localparam logic [31:0] B1 = 32'h0000_0001;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  logic dp_rd = 1'b0;
  logic [31:0] expq[$];
  logic [31:0] mskq[$];
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  integer seed = 32'h0000_8708;
  logic [31:0] rd;
  logic [15:0] dat[4];
  logic [5:0] adr[4];
  qdsm_if lnk_a();
  qdsm_host #(.STARTUP(STARTUP)) u_qdsm_host (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .irq_o(irq),
    .lnk(lnk_a.host));
  qdsm_device #(.AW(AW)) u_qdsm_device (.clock_i(clock_i), .rst_i(rst_i), .lnk(lnk_a.device));
  qdsm_checker #(.AW(AW), .STARTUP(STARTUP)) u_qdsm_checker (.clock_i(clock_i), .rst_i(rst_i),
    .sel_n(lnk_a.sel_n), .write_sel(lnk_a.write_sel), .byte_width_select(lnk_a.byte_width_select),
    .sequential_mode(lnk_a.sequential_mode), .init(lnk_a.init), .done(lnk_a.done),
    .ovf_in(lnk_a.ovf_in), .ovf_out(lnk_a.ovf_out), .dq_oe_n(lnk_a.dq_oe_n));
  initial forever #20 clock_i = ~clock_i;
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Zero mask marks a poll: popped but not compared
  task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] wd,
      input logic [31:0] ex, input logic [31:0] mk);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= 32'(off);
    hwrite <= w;
    if (!w) begin
      expq.push_back(ex & mk);
      mskq.push_back(mk);
    end
    do @(posedge clock_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    dp_rd <= !w;
    do @(posedge clock_i); while (hready !== 1'b1);
    rd = hrdata;
    dp_rd <= 1'b0;
  endtask
  always @(posedge clock_i) begin
    if (dp_rd && hready === 1'b1) begin
      if (mskq[0] != 0) check("hrdata", expq[0], hrdata & mskq[0]);
      expq.pop_front();
      mskq.pop_front();
    end
  end
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    bus(1'b1, off, d, '0, '0);
  endtask
  task automatic poll(input logic [7:0] off, input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, off, '0, '0, '0);
      n++;
    end while (rd[b] !== v && n < 600);
    check("poll", 32'(v), 32'(rd[b]));
  endtask
  task automatic acc(input logic [1:0] d, input logic w, input logic x8, input logic [5:0] a,
      input logic [15:0] v);
    logic [31:0] c;
    c = (B1 << qdsm_pkg::CTRL_GO) | (32'(w) << qdsm_pkg::CTRL_WR) | (B1 << qdsm_pkg::CTRL_OE);
    c = c | (32'(x8) << qdsm_pkg::CTRL_X8) | (32'(d) << qdsm_pkg::CTRL_DIE_LO);
    wr(qdsm_pkg::OFF_ADDR, 32'(a));
    wr(qdsm_pkg::OFF_WDATA, 32'(v));
    wr(qdsm_pkg::OFF_CTRL, c);
    poll(qdsm_pkg::OFF_STAT, 0, 1'b0);
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(negedge clock_i);
    check("irq", 32'(v), 32'(irq));
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    lnk_a.write_ok <= 1'b1;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    check("sel_n", 32'h0000_000F, 32'(lnk_a.sel_n));
    check("ovf_err", 32'h0000_0000, 32'({lnk_a.ovf_out, lnk_a.err}));
    wr(qdsm_pkg::OFF_CTRL, B1);
    bus(1'b0, qdsm_pkg::OFF_STAT, '0, 32'h0000_0000, 32'h0000_0005);
    poll(qdsm_pkg::OFF_STAT, 2, 1'b1);
    bus(1'b0, qdsm_pkg::OFF_MASK, '0, 32'h0000_0000, 32'h0000_0007);
    wr(8'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h1C, '0, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(qdsm_pkg::OFF_MASK, 32'h0000_0007);
    for (int d = 0; d < 4; d++) begin
      // Top location of every die is never written, kept for the error case
      adr[d] = 6'($random(seed)) & 6'h1F;
      dat[d] = 16'($random(seed));
      acc(2'(d), 1'b1, 1'b0, adr[d], dat[d]);
      bus(1'b0, qdsm_pkg::OFF_IRQ, '0, 32'h0000_0001, 32'h0000_0001);
      acc(2'(d), 1'b0, 1'b0, adr[d], ~dat[d]);
      irq_is(1'b1);
      bus(1'b0, qdsm_pkg::OFF_RDATA, '0, 32'(dat[d]), 32'h0000_FFFF);
      bus(1'b0, qdsm_pkg::OFF_IRQ, '0, 32'h0000_0001, 32'h0000_0005);
      irq_is(1'b0);
    end
    lnk_a.write_ok <= 1'b0;
    acc(2'd0, 1'b1, 1'b0, adr[0], ~dat[0]);
    lnk_a.write_ok <= 1'b1;
    acc(2'd0, 1'b0, 1'b0, adr[0], '0);
    bus(1'b0, qdsm_pkg::OFF_RDATA, '0, 32'(dat[0]), 32'h0000_FFFF);
    acc(2'd3, 1'b0, 1'b0, 6'h3F, '0);
    bus(1'b0, qdsm_pkg::OFF_IRQ, '0, 32'h0000_0004, 32'h0000_0004);
    acc(2'd1, 1'b0, 1'b1, adr[1], '0);
    bus(1'b0, qdsm_pkg::OFF_RDATA, '0, 32'(dat[1][7:0]), 32'h0000_FFFF);
    wr(qdsm_pkg::OFF_MASK, 32'h0000_0000);
    acc(2'd2, 1'b0, 1'b0, adr[2], '0);
    irq_is(1'b0);
    bus(1'b0, qdsm_pkg::OFF_IRQ, '0, 32'h0000_0001, 32'h0000_0001);
    wr(qdsm_pkg::OFF_MASK, 32'h0000_0007);
    // Repeated runs must each restart the counter from zero; the last in byte mode
    for (int i = 0; i < 3; i++) begin
      wr(qdsm_pkg::OFF_CTRL, B1 | (B1 << qdsm_pkg::CTRL_SEQ) | (B1 << qdsm_pkg::CTRL_OE)
         | (32'(i == 2) << qdsm_pkg::CTRL_X8));
      poll(qdsm_pkg::OFF_STAT, 0, 1'b0);
      irq_is(1'b1);
      bus(1'b0, qdsm_pkg::OFF_IRQ, '0, 32'h0000_0002, 32'h0000_0002);
      wr(qdsm_pkg::OFF_CTRL, B1 << qdsm_pkg::CTRL_STOP);
      poll(qdsm_pkg::OFF_STAT, 0, 1'b0);
    end
    results();
  end
endmodule
